// file: common/lcs_pkg.sv
/*
  Constants and carrier types for the bus controller register bank.
  Assumes a single system clock at 10 MHz and a frame engine outside
  this bank that reports frame events as one-cycle pulses.
*/
package lcs_pkg;

  // register indexes on the plain register port
  localparam logic [3:0] ADDR_DATA_FIRST = 4'h0;
  localparam logic [3:0] ADDR_DATA_LAST  = 4'h7;
  localparam logic [3:0] ADDR_CONTROL    = 4'h8;
  localparam logic [3:0] ADDR_STATUS     = 4'h9;
  localparam logic [3:0] ADDR_ERROR      = 4'hA;
  localparam logic [3:0] ADDR_MODE       = 4'hF;

  // control bit positions
  localparam int CTL_STOP    = 7;
  localparam int CTL_SLEEP   = 6;
  localparam int CTL_DIR     = 5;
  localparam int CTL_ACK     = 4;
  localparam int CTL_CLR_INT = 3;
  localparam int CTL_CLR_ERR = 2;
  localparam int CTL_WAKE    = 1;
  localparam int CTL_START   = 0;

  // status bit positions
  localparam int ST_ACTIVE  = 7;
  localparam int ST_IDLE_TO = 6;
  localparam int ST_ABORT   = 5;
  localparam int ST_DATA_REQUEST_FLAG   = 4;
  localparam int ST_INT     = 3;
  localparam int ST_ERROR   = 2;
  localparam int ST_WAKEUP  = 1;
  localparam int ST_DONE    = 0;

  // mode register bit
  localparam int MODE_MASTER = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // idle timeout: four seconds at 100 ns
  localparam longint IDLE_TIMEOUT_MS = 4000;
  localparam longint CLK_PERIOD_NS   = 100;
  localparam longint IDLE_CYCLES     = (IDLE_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int     IDLE_CNT_W      = 26;

  // events reported by the frame engine; the flags are one-cycle pulses, the bits, index and byte ride alongside
  typedef struct packed {
    logic       sync_break;
    logic       frame_start;
    logic       frame_done;
    logic       frame_error;
    logic [4:0] err_bits;
    logic       data_id;
    logic       sleep_frame;
    logic       wakeup_rx;
    logic       ack_taken;
    logic       rx_valid;
    logic [2:0] rx_index;
    logic [7:0] rx_byte;
  } lcs_event_s;

  // control levels handed to the frame engine
  typedef struct packed {
    logic master;
    logic transmit;
    logic start;
    logic ack;
    logic blocked;
    logic sleeping;
    logic wake_send;
  } lcs_ctrl_s;

endpackage : lcs_pkg

// file: src/lcs_regs.sv
/*
  Register bank of the bus controller: eight frame bytes, control,
  status, error flags and a mode register.
  Assumes the register master and frame engine run on i_clk_sys; the
  bus receive pin arrives asynchronously and is synchronised here.
*/
// Added by the designer: strobed register access.
`timescale 1ns/1ps

module lcs_regs #(
  parameter logic [25:0] IDLE_LIMIT = 26'(lcs_pkg::IDLE_CYCLES)
) (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  // register port
  input  wire logic [3:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  // bus pin and frame engine
  input  wire logic              i_bus_rx,
  input  wire lcs_pkg::lcs_event_s i_evt,
  output lcs_pkg::lcs_ctrl_s     o_ctrl,
  output logic      [63:0]       o_frame_bytes
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] frame_byte_value [8];
  logic       master;
  logic       sleep_en;
  logic       frame_direction;
  logic       data_request_ack;
  logic       wakeup_request;
  logic       frame_start_request;
  logic       blocked;
  logic       sleeping;
  logic       bus_active;
  logic       bus_idle_timeout;
  logic       aborted;
  logic       data_request_flag;
  logic       pending_interrupt_flag;
  logic       err_status;
  logic       wakeup_seen;
  logic       done;
  logic       in_frame;
  logic [4:0] error_flags_register;
  logic [25:0] idle_cnt;
  logic       rx_meta;
  logic       rx_sync;
  logic       rx_prev;

  logic       wr_ctl;
  logic       slave_evt;
  logic       next_idle;
  logic [7:0] ctrl_view;
  logic [7:0] status_view;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  assign wr_ctl    = i_wr && hit(i_addr, lcs_pkg::ADDR_CONTROL);
  // slave traffic ignored while stop holds, except the freeing break
  assign slave_evt = !master && !blocked;
  assign next_idle = (idle_cnt == IDLE_LIMIT - 26'h0000001);

  ////////////////////////////////////////////////////////////////////////
  // frame bytes
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_byte
      always_ff @(posedge i_clk_sys)
      begin
        if (!i_rst_n)
          frame_byte_value[gi] <= lcs_pkg::RESET_BYTE;
        else if (i_wr && i_addr == 4'(gi))
          frame_byte_value[gi] <= i_wdata;
        else if (i_evt.rx_valid && i_evt.rx_index == 3'(gi) && !frame_direction && !blocked)
          frame_byte_value[gi] <= i_evt.rx_byte;
      end
      assign o_frame_bytes[gi*8 +: 8] = frame_byte_value[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // mode and control bits
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      master <= 1'b0;
    else if (i_wr && hit(i_addr, lcs_pkg::ADDR_MODE))
      master <= i_wdata[lcs_pkg::MODE_MASTER];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      sleep_en        <= 1'b0;
      frame_direction <= 1'b0;
    end
    else if (wr_ctl)
    begin
      sleep_en        <= i_wdata[lcs_pkg::CTL_SLEEP] && !master;
      frame_direction <= i_wdata[lcs_pkg::CTL_DIR];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      data_request_ack <= 1'b0;
    else if (wr_ctl && i_wdata[lcs_pkg::CTL_ACK] && !master)
      data_request_ack <= 1'b1;
    else if (i_evt.ack_taken)
      data_request_ack <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      frame_start_request <= 1'b0;
    else if (wr_ctl && i_wdata[lcs_pkg::CTL_START] && master)
      frame_start_request <= 1'b1;
    else if (i_evt.frame_done || i_evt.frame_error)
      frame_start_request <= 1'b0;
  end

  // wake request held one cycle so the engine sees a pulse, then drops
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      wakeup_request <= 1'b0;
    else if (wr_ctl && i_wdata[lcs_pkg::CTL_WAKE] && sleeping)
      wakeup_request <= 1'b1;
    else
      wakeup_request <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      blocked <= 1'b0;
    else if (wr_ctl && i_wdata[lcs_pkg::CTL_STOP] && !master)
      blocked <= 1'b1;
    else if (i_evt.sync_break)
      blocked <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      sleeping <= 1'b0;
    else if (wakeup_request)
      sleeping <= 1'b0;
    else if (sleeping && !sleep_en && i_evt.wakeup_rx)
      sleeping <= 1'b0;
    else if (!master && sleep_en && (i_evt.sleep_frame || bus_idle_timeout))
      sleeping <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // bus activity: two-flop sync, then edge watch
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_meta <= i_bus_rx;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      in_frame <= 1'b0;
    else if (i_evt.sync_break || i_evt.frame_start)
      in_frame <= 1'b1;
    else if (i_evt.frame_done || i_evt.frame_error)
      in_frame <= 1'b0;
  end

  // activity means a frame underway, the line held dominant, or a line edge
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      bus_active <= 1'b0;
    else
      bus_active <= in_frame || !rx_sync || (rx_sync != rx_prev);
  end

  // 26-bit counter covers four seconds at 10 MHz
  // holds at IDLE_LIMIT - 1 so the flag cannot wrap back to clear
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      idle_cnt <= 26'h0000000;
    else if (bus_active || sleeping || master)
      idle_cnt <= 26'h0000000;
    else if (!next_idle)
      idle_cnt <= idle_cnt + 26'h0000001;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      bus_idle_timeout <= 1'b0;
    else if (bus_active || sleeping || master)
      bus_idle_timeout <= 1'b0;
    else if (next_idle)
      bus_idle_timeout <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      aborted <= 1'b0;
    else if (wr_ctl && i_wdata[lcs_pkg::CTL_STOP] && !master)
      aborted <= 1'b1;
    else if (i_evt.sync_break && !master)
      aborted <= in_frame;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      data_request_flag <= 1'b0;
    else if (i_evt.data_id && slave_evt)
      data_request_flag <= 1'b1;
    // a fresh break or the software ack retires the request
    else if (i_evt.sync_break || data_request_ack)
      data_request_flag <= 1'b0;
  end

  // set beats clear in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      pending_interrupt_flag <= 1'b0;
    else if ((i_evt.data_id && slave_evt) || i_evt.frame_done || i_evt.frame_error || i_evt.wakeup_rx)
      pending_interrupt_flag <= 1'b1;
    else if (wr_ctl && i_wdata[lcs_pkg::CTL_CLR_INT])
      pending_interrupt_flag <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      err_status           <= 1'b0;
      error_flags_register <= 5'h00;
    end
    else if (i_evt.frame_error)
    begin
      err_status           <= 1'b1;
      error_flags_register <= error_flags_register | i_evt.err_bits;
    end
    else if (wr_ctl && i_wdata[lcs_pkg::CTL_CLR_ERR])
    begin
      err_status           <= 1'b0;
      error_flags_register <= 5'h00;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      wakeup_seen <= 1'b0;
    else if (wakeup_request || i_evt.wakeup_rx)
      wakeup_seen <= 1'b1;
    else if (i_evt.sync_break)
      wakeup_seen <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      done <= 1'b0;
    else if (i_evt.frame_done)
      done <= 1'b1;
    else if (i_evt.frame_start)
      done <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // read views laid out by the shared bit positions; unset bits read zero
  always_comb
  begin
    ctrl_view                         = lcs_pkg::RESET_BYTE;
    ctrl_view[lcs_pkg::CTL_SLEEP]     = sleep_en;
    ctrl_view[lcs_pkg::CTL_DIR]       = frame_direction;
    ctrl_view[lcs_pkg::CTL_ACK]       = data_request_ack;
    ctrl_view[lcs_pkg::CTL_WAKE]      = wakeup_request;
    ctrl_view[lcs_pkg::CTL_START]     = frame_start_request;
  end

  always_comb
  begin
    status_view                       = lcs_pkg::RESET_BYTE;
    status_view[lcs_pkg::ST_ACTIVE]   = bus_active;
    status_view[lcs_pkg::ST_IDLE_TO]  = bus_idle_timeout;
    status_view[lcs_pkg::ST_ABORT]    = aborted;
    status_view[lcs_pkg::ST_DATA_REQUEST_FLAG]    = data_request_flag;
    status_view[lcs_pkg::ST_INT]      = pending_interrupt_flag;
    status_view[lcs_pkg::ST_ERROR]    = err_status;
    status_view[lcs_pkg::ST_WAKEUP]   = wakeup_seen;
    status_view[lcs_pkg::ST_DONE]     = done;
  end

  ////////////////////////////////////////////////////////////////////////
  // read port; write-only bits read zero
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else if (!i_rd)
      o_rdata <= 8'h00;
    else if (i_addr <= lcs_pkg::ADDR_DATA_LAST)
      o_rdata <= frame_byte_value[i_addr[2:0]];
    else if (hit(i_addr, lcs_pkg::ADDR_CONTROL))
      o_rdata <= ctrl_view;
    else if (hit(i_addr, lcs_pkg::ADDR_STATUS))
      o_rdata <= status_view;
    else if (hit(i_addr, lcs_pkg::ADDR_ERROR))
      o_rdata <= {3'b000, error_flags_register};
    else if (hit(i_addr, lcs_pkg::ADDR_MODE))
      o_rdata <= {7'h00, master};
    else
      o_rdata <= 8'h00;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_ctrl <= '0;
    else
      o_ctrl <= '{master: master, transmit: frame_direction, start: frame_start_request,
                  ack: data_request_ack, blocked: blocked, sleeping: sleeping,
                  wake_send: wakeup_request};
  end

endmodule : lcs_regs

// file: tb/lcs_engine_model.sv
/*
  Frame engine and bus model: pulses one event per command.
  Assumes commands from the bench, one cycle of i_go each.
*/
`timescale 1ns/1ps
module lcs_engine_model (
  // clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_n,
  // bench commands
  input  wire logic               i_go,
  input  wire logic               i_slow,
  input  wire logic [2:0]         i_cmd,
  input  wire logic [2:0]         i_idx,
  input  wire logic [7:0]         i_arg,
  // bank side
  input  wire lcs_pkg::lcs_ctrl_s i_ctrl,
  output lcs_pkg::lcs_event_s     o_evt,
  output logic                    o_bus_rx
);
  logic [3:0] ack_wait;
  logic       ack_d;
  always_ff @(posedge i_clk_sys)
  begin
    o_evt.sync_break <= i_go && i_cmd == 3'h0;
    o_evt.frame_start <= i_go && i_cmd == 3'h1;
    o_evt.frame_done <= i_go && i_cmd == 3'h2;
    o_evt.frame_error <= i_go && i_cmd == 3'h3;
    o_evt.data_id <= i_go && i_cmd == 3'h4;
    o_evt.sleep_frame <= i_go && i_cmd == 3'h5;
    o_evt.wakeup_rx <= i_go && i_cmd == 3'h6;
    o_evt.rx_valid <= i_go && i_cmd == 3'h7;
    o_evt.err_bits <= i_arg[4:0];
    o_evt.rx_index <= i_idx;
    // byte lanes show junk when not valid
    o_evt.rx_byte <= i_go ? i_arg : ~i_arg;
    // slow mode lets the bench see ack pending
    o_evt.ack_taken <= ack_wait == 4'h1;
    ack_d <= i_ctrl.ack;
    if (!i_rst_n)
      ack_wait <= 4'h0;
    else if (i_ctrl.ack && !ack_d)
      ack_wait <= i_slow ? 4'h8 : 4'h1;
    else if (ack_wait != 4'h0)
      ack_wait <= ack_wait - 4'h1;
    // dominant inside a frame, recessive pull-up otherwise
    if (!i_rst_n)
      o_bus_rx <= 1'b1;
    else if (i_go && i_cmd <= 3'h1)
      o_bus_rx <= 1'b0;
    else if (i_go && i_cmd <= 3'h3)
      o_bus_rx <= 1'b1;
  end
endmodule : lcs_engine_model

// file: tb/lcs_regs_checker.sv
/*
  Port checker for the register bank, attached by bind.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module lcs_regs_checker #(
  parameter logic [25:0] IDLE_LIMIT = 26'h14
) (
  // clock and reset
  input wire logic                i_clk_sys,
  input wire logic                i_rst_n,
  // register port
  input wire logic [3:0]          i_addr,
  input wire logic [7:0]          i_wdata,
  input wire logic                i_wr,
  input wire logic                i_rd,
  input wire logic [7:0]          o_rdata,
  // engine side
  input wire logic                i_bus_rx,
  input wire lcs_pkg::lcs_event_s i_evt,
  input wire lcs_pkg::lcs_ctrl_s  o_ctrl,
  input wire logic [63:0]         o_frame_bytes
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////
  property p_rdata_quiet;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data not zero outside a read");
  property p_data_write;
    i_wr && i_addr <= 4'h7 && !i_evt.rx_valid |=> o_frame_bytes[8*$past(i_addr[2:0]) +: 8] == $past(i_wdata);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("frame byte not written");
  property p_ctrl_zero;
    i_rd && i_addr == lcs_pkg::ADDR_CONTROL |=> o_rdata[7] == 1'b0 && o_rdata[3:2] == 2'h0;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("write-only control bits read nonzero");
  property p_dir;
    i_wr && i_addr == lcs_pkg::ADDR_CONTROL |-> ##2 o_ctrl.transmit == $past(i_wdata[lcs_pkg::CTL_DIR], 2);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction not followed");
  property p_mode;
    i_wr && i_addr == lcs_pkg::ADDR_MODE |-> ##2 o_ctrl.master == $past(i_wdata[0], 2);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode not followed");
  property p_start_clear;
    o_ctrl.start && i_evt.frame_done && !i_wr |-> ##2 !o_ctrl.start;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("start not cleared at frame end");
  property p_ack_clear;
    o_ctrl.ack && i_evt.ack_taken && !i_wr |-> ##2 !o_ctrl.ack;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("ack not cleared when taken");
  property p_wake_pulse;
    o_ctrl.wake_send |=> !o_ctrl.wake_send && !o_ctrl.sleeping;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake request not a pulse ending sleep");
  // blocking may only end through a sync break
  property p_blocked_hold;
    o_ctrl.blocked && !i_evt.sync_break && !$past(i_evt.sync_break) |=> o_ctrl.blocked;
  endproperty
  a_blocked_hold: assert property (p_blocked_hold)
    else $error("blocking ended without sync break");
endmodule : lcs_regs_checker

bind lcs_regs lcs_regs_checker #(.IDLE_LIMIT(IDLE_LIMIT)) u_checker (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bus_rx(i_bus_rx),
  .i_evt(i_evt), .o_ctrl(o_ctrl), .o_frame_bytes(o_frame_bytes)
);

// file: tb/test_lcs_regs.sv
/*
  Self-checking bench for lcs_regs through its register port.
  Assumes the engine model in place of the frame engine.
*/
`timescale 1ns/1ps
module test_lcs_regs;
  localparam logic [25:0] IDLE = 26'hC8;
  localparam logic [3:0]  CT   = lcs_pkg::ADDR_CONTROL;
  localparam logic [3:0]  ST   = lcs_pkg::ADDR_STATUS;
  logic                i_clk_sys = 1'b0;
  logic                i_rst_n   = 1'b0;
  logic [3:0]          i_addr    = 4'h0;
  logic [7:0]          i_wdata   = 8'h00;
  logic                i_wr      = 1'b0;
  logic                i_rd      = 1'b0;
  logic                go        = 1'b0;
  logic                slow      = 1'b0;
  logic [2:0]          cmd       = 3'h0;
  logic [2:0]          idx       = 3'h0;
  logic [7:0]          arg       = 8'h00;
  logic [7:0]          o_rdata;
  logic                bus_rx;
  logic [63:0]         frame_bytes;
  lcs_pkg::lcs_event_s evt;
  lcs_pkg::lcs_ctrl_s  ctrl;
  int                  err_total = 0;
  int                  tests_run = 0;
  always #50 i_clk_sys = ~i_clk_sys;
  lcs_regs #(.IDLE_LIMIT(IDLE)) dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bus_rx(bus_rx),
    .i_evt(evt), .o_ctrl(ctrl), .o_frame_bytes(frame_bytes)
  );
  lcs_engine_model u_model (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_go(go), .i_slow(slow), .i_cmd(cmd),
    .i_idx(idx), .i_arg(arg), .i_ctrl(ctrl), .o_evt(evt), .o_bus_rx(bus_rx)
  );
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n, input logic [7:0] m = 8'hFF);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    check(n, o_rdata & m, e);
  endtask : rd
  task automatic ev(input logic [2:0] c, input logic [7:0] a);
    @(posedge i_clk_sys);
    go <= 1'b1;
    cmd <= c;
    arg <= a;
    @(posedge i_clk_sys);
    go <= 1'b0;
    repeat (2) @(negedge i_clk_sys);
  endtask : ev
  task automatic final_report;
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge i_clk_sys);
    err_total++;
    final_report();
  end
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00, "reset", 8'h3F);
    for (int a = 0; a < 8; a++) wr(4'(a), 8'(8'hA1 + 8'(a * 17)));
    for (int a = 0; a < 8; a++) rd(4'(a), 8'(8'hA1 + 8'(a * 17)), "data");
    check("bytes", frame_bytes[63:56], 8'h18);
    // master frame
    wr(lcs_pkg::ADDR_MODE, 8'h01);
    wr(CT, 8'h21);
    rd(CT, 8'h21, "start");
    ev(3'h1, 8'h00);
    rd(ST, 8'h80, "active", 8'h81);
    ev(3'h2, 8'h00);
    rd(ST, 8'h09, "done", 8'h7F);
    rd(CT, 8'h20, "start end");
    wr(CT, 8'h28);
    rd(ST, 8'h01, "int clear", 8'h7F);
    wr(CT, 8'hD0);
    rd(CT, 8'h00, "slave bits");
    wr(CT, 8'h01);
    ev(3'h3, 8'h15);
    rd(CT, 8'h00, "start err");
    rd(ST, 8'h0D, "error", 8'h7F);
    rd(lcs_pkg::ADDR_ERROR, 8'h15, "err reg");
    wr(CT, 8'h0C);
    rd(ST, 8'h01, "err clear", 8'h7F);
    rd(lcs_pkg::ADDR_ERROR, 8'h00, "err flags");
    // slave data request, slow ack
    wr(lcs_pkg::ADDR_MODE, 8'h00);
    wr(CT, 8'h01);
    rd(CT, 8'h00, "start slave");
    ev(3'h4, 8'h00);
    rd(ST, 8'h19, "dreq", 8'h7F);
    slow <= 1'b1;
    wr(CT, 8'h18);
    rd(CT, 8'h10, "ack held");
    repeat (16) @(negedge i_clk_sys);
    rd(CT, 8'h00, "ack end");
    rd(ST, 8'h01, "dreq end", 8'h7F);
    // stop, early break, clean break
    ev(3'h1, 8'h00);
    wr(CT, 8'h80);
    rd(CT, 8'h00, "stop");
    rd(ST, 8'h20, "abort", 8'h21);
    ev(3'h7, 8'h3C);
    rd(4'h0, 8'hA1, "blocked");
    ev(3'h0, 8'h00);
    rd(ST, 8'h20, "early", 8'h20);
    ev(3'h2, 8'h00);
    ev(3'h0, 8'h00);
    rd(ST, 8'h00, "abort end", 8'h20);
    ev(3'h7, 8'h3C);
    rd(4'h0, 8'h3C, "rx byte");
    // sleep and wake
    wr(CT, 8'h40);
    ev(3'h5, 8'h00);
    @(negedge i_clk_sys);
    check("sleep", {7'h00, ctrl.sleeping}, 8'h01);
    wr(CT, 8'h42);
    repeat (3) @(negedge i_clk_sys);
    check("woken", {7'h00, ctrl.sleeping}, 8'h00);
    wr(CT, 8'h40);
    ev(3'h5, 8'h00);
    wr(CT, 8'h00);
    @(negedge i_clk_sys);
    check("asleep", {7'h00, ctrl.sleeping}, 8'h01);
    ev(3'h6, 8'h00);
    @(negedge i_clk_sys);
    check("wake rx", {7'h00, ctrl.sleeping}, 8'h00);
    rd(ST, 8'h02, "wakeup", 8'h02);
    // close the frame and free the line so the idle count can run
    ev(3'h2, 8'h00);
    repeat (250) @(negedge i_clk_sys);
    rd(ST, 8'h40, "idle", 8'h40);
    final_report();
  end
endmodule : test_lcs_regs
